// ===== hw/ashl_pkg.sv
// Purpose: shared constants and types of the accelerometer host link
// Assumes: eight-byte register image, three-bit register pointer
// Notes:   the register map below is internal to this block
package ashl_pkg;

    // ---------------------------------------------------------------
    // bus addressing
    // ---------------------------------------------------------------
    localparam logic [6:0] I2C_ADDR_HI   = 7'h1D;
    localparam logic [6:0] I2C_ADDR_LO   = 7'h53;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam int unsigned SPI_RD_BIT   = 7;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [2:0] REG_X_LO      = 3'h0;
    localparam logic [2:0] REG_X_HI      = 3'h1;
    localparam logic [2:0] REG_Y_LO      = 3'h2;
    localparam logic [2:0] REG_Y_HI      = 3'h3;
    localparam logic [2:0] REG_Z_LO      = 3'h4;
    localparam logic [2:0] REG_Z_HI      = 3'h5;
    localparam logic [2:0] REG_STATUS    = 3'h6;
    localparam logic [2:0] REG_CONFIG    = 3'h7;

    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int unsigned STAT_READY   = 0;
    localparam int unsigned STAT_OVERRUN = 1;
    localparam int unsigned CFG_3WIRE    = 0;
    localparam int unsigned CFG_IRQ1_EN  = 1;
    localparam int unsigned CFG_IRQ2_EN  = 2;
    localparam logic [7:0] CFG_RESET     = 8'h00;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] z;
        logic signed [15:0] y;
        logic signed [15:0] x;
    } ashl_sample_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] data;
    } ashl_wr_t;

    typedef logic [7:0][7:0] ashl_image_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } ashl_i2c_st_t;

endpackage : ashl_pkg

// ===== hw/ashl_sync.sv
// Purpose: two-stage level synchroniser, one per bit
// Assumes: inputs are levels or toggles, not pulses
// Notes:   only the second stage may be read
`timescale 1ns/1ns
module ashl_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : ashl_sync

// ===== hw/ashl_spi_slave.sv
// Purpose: spi target on the master's serial clock
// Assumes: clock idles high, sample on rise, shift out on fall
// Notes:   chip select high holds the receive and transmit sides in reset
`timescale 1ns/1ns
module ashl_spi_slave
    import ashl_pkg::*;
(
    input  wire logic                  sclk,
    input  wire logic                  rstn,
    input  wire logic                  cs_n,
    input  wire logic                  sdi_i,
    input  wire logic                  three_wire,
    input  wire ashl_pkg::ashl_image_t image,
    output logic                       dout_q,
    output logic                       oe3_q,
    output logic                       oe4_q,
    output ashl_pkg::ashl_wr_t         wr_q,
    output logic                       wr_tgl_q,
    output logic [2:0]                 rd_addr_q,
    output logic                       rd_tgl_q
);

    logic       frame_rst_n;
    logic [2:0] cnt_q;
    logic [6:0] sr_q;
    logic       cmd_done_q;
    logic       rd_q;
    logic [2:0] addr_q;
    logic [7:0] byte_in;

    assign frame_rst_n = rstn & ~cs_n;
    assign byte_in     = {sr_q, sdi_i};

    // ---------------------------------------------------------------
    // receive side, one bit per master clock rise
    // ---------------------------------------------------------------
    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            cnt_q      <= '0;
            sr_q       <= '0;
            cmd_done_q <= 1'b0;
            rd_q       <= 1'b0;
            addr_q     <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + 3'd1;
            sr_q  <= byte_in[6:0];
            if (cnt_q == 3'd7 && !cmd_done_q)
            begin
                cmd_done_q <= 1'b1;
                rd_q       <= byte_in[SPI_RD_BIT];
                addr_q     <= byte_in[2:0];
            end
            else if (cnt_q == 3'd7)
                addr_q <= addr_q + 3'd1;
        end
    end

    // toggles survive frame end, so only the global reset clears them
    always_ff @(posedge sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q      <= '0;
            wr_tgl_q  <= 1'b0;
            rd_addr_q <= '0;
            rd_tgl_q  <= 1'b0;
        end
        else if (!cs_n && cnt_q == 3'd7 && cmd_done_q)
        begin
            if (rd_q)
            begin
                rd_addr_q <= addr_q;
                rd_tgl_q  <= ~rd_tgl_q;
            end
            else
            begin
                wr_q     <= '{addr: addr_q, data: byte_in};
                wr_tgl_q <= ~wr_tgl_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // transmit side, msb first on falling edges
    // ---------------------------------------------------------------
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            dout_q <= 1'b0;
            oe3_q  <= 1'b0;
            oe4_q  <= 1'b0;
        end
        else
        begin
            oe3_q  <= cmd_done_q & rd_q & three_wire;
            oe4_q  <= cmd_done_q & rd_q & ~three_wire;
            dout_q <= image[addr_q][~cnt_q];
        end
    end

    a_spi_three_wire: assert property (
        @(posedge sclk) disable iff (!frame_rst_n)
        ($rose(cmd_done_q) && rd_q && three_wire) |-> (oe3_q && !oe4_q))
        else $error("3-wire read does not drive data-in pin");

    a_spi_four_wire: assert property (
        @(posedge sclk) disable iff (!frame_rst_n)
        ($rose(cmd_done_q) && rd_q && !three_wire) |-> (oe4_q && !oe3_q))
        else $error("4-wire read does not drive data-out pin");

    a_spi_wr_capture: assert property (
        @(posedge sclk) disable iff (!frame_rst_n)
        (cmd_done_q && !rd_q && cnt_q == 3'd7)
        |=> (wr_tgl_q != $past(wr_tgl_q)
             && wr_q.data == {$past(sr_q), $past(sdi_i)}))
        else $error("spi write byte not taken from data-in");

endmodule : ashl_spi_slave

// ===== hw/ashl_top.sv
// Purpose: accelerometer side of the i2c / spi link to the logic master
// Assumes: samples arrive on mclk; the master clocks the serial link
// Notes:   i2c is oversampled on mclk, spi runs on the serial clock
`timescale 1ns/1ns
module ashl_top
    import ashl_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   sensor_serial_clock,
    input  wire logic                   sensor_mode_select_n,
    input  wire logic                   sensor_serial_in_io_i,
    output logic                        sensor_serial_in_io_o,
    output logic                        sensor_serial_in_io_oe,
    input  wire logic                   sensor_serial_out_addr_sel_i,
    output logic                        sensor_serial_out_addr_sel_o,
    output logic                        sensor_serial_out_addr_sel_oe,
    output logic                        sensor_irq_first,
    output logic                        sensor_irq_second,
    input  wire ashl_pkg::ashl_sample_t accel_sample,
    input  wire logic                   accel_valid
);

    // ---------------------------------------------------------------
    // pin synchronisers and edge detect
    // ---------------------------------------------------------------
    logic [3:0]   pins_s;
    logic         scl_s;
    logic         sda_s;
    logic         csn_s;
    logic         asel_s;
    logic         scl_p_q;
    logic         sda_p_q;
    logic         scl_rise;
    logic         scl_fall;
    logic         i2c_start;
    logic         i2c_stop;
    logic         spi_mode;
    logic [6:0]   own_addr;

    ashl_sync #(.W(4)) u_pin_sync (
        .clk  (mclk),
        .rstn (rstn),
        .d    ({sensor_serial_clock, sensor_serial_in_io_i,
                sensor_mode_select_n, sensor_serial_out_addr_sel_i}),
        .q    (pins_s)
    );

    assign scl_s  = pins_s[3];
    assign sda_s  = pins_s[2];
    assign csn_s  = pins_s[1];
    assign asel_s = pins_s[0];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign i2c_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign i2c_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign spi_mode  = ~csn_s;
    assign own_addr  = asel_s ? I2C_ADDR_HI : I2C_ADDR_LO;

    // ---------------------------------------------------------------
    // register image
    // ---------------------------------------------------------------
    ashl_sample_t data_q;
    ashl_sample_t pend_data_q;
    logic         pend_q;
    logic         ready_q;
    logic         ovr_q;
    logic [7:0]   cfg_q;
    ashl_image_t  image;
    logic [7:0]   stat_byte;

    always_comb
    begin
        stat_byte               = '0;
        stat_byte[STAT_READY]   = ready_q;
        stat_byte[STAT_OVERRUN] = ovr_q;
    end

    // two's complement words, low byte first on both buses
    assign image = {cfg_q, stat_byte, data_q.z[15:8], data_q.z[7:0],
                    data_q.y[15:8], data_q.y[7:0],
                    data_q.x[15:8], data_q.x[7:0]};

    // ---------------------------------------------------------------
    // spi engine and its event crossing
    // ---------------------------------------------------------------
    ashl_wr_t     spi_wr;
    logic         spi_wr_tgl;
    logic [2:0]   spi_rd_addr;
    logic         spi_rd_tgl;
    logic         spi_dout;
    logic         spi_oe3;
    logic         spi_oe4;
    logic [1:0]   tgl_s;
    logic [1:0]   tgl_p_q;
    logic         spi_wr_evt;
    logic         spi_rd_evt;

    // image is quasi-static: data updates are held off during frames
    ashl_spi_slave u_spi (
        .sclk       (sensor_serial_clock),
        .rstn       (rstn),
        .cs_n       (sensor_mode_select_n),
        .sdi_i      (sensor_serial_in_io_i),
        .three_wire (cfg_q[CFG_3WIRE]),
        .image      (image),
        .dout_q     (spi_dout),
        .oe3_q      (spi_oe3),
        .oe4_q      (spi_oe4),
        .wr_q       (spi_wr),
        .wr_tgl_q   (spi_wr_tgl),
        .rd_addr_q  (spi_rd_addr),
        .rd_tgl_q   (spi_rd_tgl)
    );

    ashl_sync #(.W(2)) u_evt_sync (
        .clk  (mclk),
        .rstn (rstn),
        .d    ({spi_wr_tgl, spi_rd_tgl}),
        .q    (tgl_s)
    );

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tgl_p_q <= '0;
        else
            tgl_p_q <= tgl_s;
    end

    assign spi_wr_evt = tgl_s[1] ^ tgl_p_q[1];
    assign spi_rd_evt = tgl_s[0] ^ tgl_p_q[0];

    // ---------------------------------------------------------------
    // i2c target
    // ---------------------------------------------------------------
    ashl_i2c_st_t st_q;
    ashl_i2c_st_t nxt_q;
    logic [3:0]   bcnt_q;
    logic [7:0]   sh_q;
    logic [7:0]   tx_q;
    logic [2:0]   ptr_q;
    logic         i2c_oe_q;
    logic         i2c_wr_q;
    logic         i2c_rd_q;
    logic [2:0]   i2c_addr_q;
    logic [7:0]   i2c_data_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q       <= ST_IDLE;
            nxt_q      <= ST_IDLE;
            bcnt_q     <= '0;
            sh_q       <= '0;
            tx_q       <= '0;
            ptr_q      <= '0;
            i2c_oe_q   <= 1'b0;
            i2c_wr_q   <= 1'b0;
            i2c_rd_q   <= 1'b0;
            i2c_addr_q <= '0;
            i2c_data_q <= '0;
        end
        else
        begin
            i2c_wr_q <= 1'b0;
            i2c_rd_q <= 1'b0;
            if (spi_mode || i2c_stop)
            begin
                st_q     <= ST_IDLE;
                i2c_oe_q <= 1'b0;
            end
            else if (i2c_start)
            begin
                st_q     <= ST_ADDR;
                bcnt_q   <= '0;
                i2c_oe_q <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (st_q)
                    ST_ADDR, ST_PTR, ST_WDATA:
                    begin
                        sh_q   <= {sh_q[6:0], sda_s};
                        bcnt_q <= bcnt_q + 4'd1;
                    end
                    ST_RDATA: bcnt_q <= bcnt_q + 4'd1;
                    ST_RACK:  if (sda_s) st_q <= ST_IDLE;
                    default:  ;
                endcase
            end
            else if (scl_fall)
            begin
                case (st_q)
                    ST_ADDR:
                        if (bcnt_q == BYTE_BITS)
                        begin
                            // byte on the wire is address then r/w bit
                            if (sh_q[7:1] == own_addr)
                            begin
                                i2c_oe_q <= 1'b1;
                                st_q     <= ST_ACK;
                                nxt_q    <= sh_q[0] ? ST_RDATA : ST_PTR;
                            end
                            else
                                st_q <= ST_IDLE;
                        end
                    ST_PTR:
                        if (bcnt_q == BYTE_BITS)
                        begin
                            ptr_q    <= sh_q[2:0];
                            i2c_oe_q <= 1'b1;
                            st_q     <= ST_ACK;
                            nxt_q    <= ST_WDATA;
                        end
                    ST_WDATA:
                        if (bcnt_q == BYTE_BITS)
                        begin
                            i2c_wr_q   <= 1'b1;
                            i2c_addr_q <= ptr_q;
                            i2c_data_q <= sh_q;
                            ptr_q      <= ptr_q + 3'd1;
                            i2c_oe_q   <= 1'b1;
                            st_q       <= ST_ACK;
                            nxt_q      <= ST_WDATA;
                        end
                    ST_ACK, ST_RACK:
                    begin
                        bcnt_q <= '0;
                        st_q   <= (st_q == ST_ACK) ? nxt_q : ST_RDATA;
                        if (st_q == ST_RACK || nxt_q == ST_RDATA)
                        begin
                            tx_q       <= image[ptr_q];
                            i2c_oe_q   <= ~image[ptr_q][7];
                            i2c_rd_q   <= 1'b1;
                            i2c_addr_q <= ptr_q;
                            ptr_q      <= ptr_q + 3'd1;
                        end
                        else
                            i2c_oe_q <= 1'b0;
                    end
                    ST_RDATA:
                        if (bcnt_q == BYTE_BITS)
                        begin
                            i2c_oe_q <= 1'b0;
                            st_q     <= ST_RACK;
                        end
                        else
                            i2c_oe_q <= ~tx_q[3'd7 - bcnt_q[2:0]];
                    default: ;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // register updates, set wins over clear
    // ---------------------------------------------------------------
    logic freeze;
    logic load;
    logic rd_zhi;
    logic rd_stat;

    // a pending sample waits for idle so a multi-byte read stays coherent
    assign freeze  = spi_mode | (st_q != ST_IDLE);
    assign load    = (accel_valid | pend_q) & ~freeze;
    assign rd_zhi  = (i2c_rd_q && i2c_addr_q == REG_Z_HI)
                   | (spi_rd_evt && spi_rd_addr == REG_Z_HI);
    assign rd_stat = (i2c_rd_q && i2c_addr_q == REG_STATUS)
                   | (spi_rd_evt && spi_rd_addr == REG_STATUS);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_q      <= '0;
            pend_q      <= 1'b0;
            pend_data_q <= '0;
        end
        else if (load)
        begin
            data_q <= accel_valid ? accel_sample : pend_data_q;
            pend_q <= 1'b0;
        end
        else if (accel_valid)
        begin
            pend_q      <= 1'b1;
            pend_data_q <= accel_sample;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_q <= 1'b0;
            ovr_q   <= 1'b0;
        end
        else
        begin
            if (load)
                ready_q <= 1'b1;
            else if (rd_zhi)
                ready_q <= 1'b0;
            if ((load && ready_q && !rd_zhi) || (accel_valid && freeze && pend_q))
                ovr_q <= 1'b1;
            else if (rd_stat)
                ovr_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            cfg_q <= CFG_RESET;
        else if (i2c_wr_q && i2c_addr_q == REG_CONFIG)
            cfg_q <= i2c_data_q;
        else if (spi_wr_evt && spi_wr.addr == REG_CONFIG)
            cfg_q <= spi_wr.data;
    end

    // ---------------------------------------------------------------
    // pins and interrupt outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sensor_irq_first  <= 1'b0;
            sensor_irq_second <= 1'b0;
        end
        else
        begin
            sensor_irq_first  <= ready_q & cfg_q[CFG_IRQ1_EN];
            sensor_irq_second <= ovr_q & cfg_q[CFG_IRQ2_EN];
        end
    end

    // spi flops sit in reset in i2c mode, so the open-drain low is free
    assign sensor_serial_in_io_o         = spi_dout;
    assign sensor_serial_in_io_oe        = spi_oe3 | i2c_oe_q;
    assign sensor_serial_out_addr_sel_o  = spi_dout;
    assign sensor_serial_out_addr_sel_oe = spi_oe4;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_addr_done;
        st_q == ST_ADDR && scl_fall && !spi_mode && !i2c_stop
        && !i2c_start && bcnt_q == BYTE_BITS;
    endsequence

    a_i2c_off_spi: assert property (
        @(posedge mclk) disable iff (!rstn)
        spi_mode |=> (st_q == ST_IDLE && !i2c_oe_q))
        else $error("i2c active while spi selected");

    a_spi_idle_i2c: assert property (
        @(posedge mclk) disable iff (!rstn)
        sensor_mode_select_n |-> (!spi_oe3 && !spi_oe4))
        else $error("spi drives a pin in i2c mode");

    a_addr_high: assert property (
        @(posedge mclk) disable iff (!rstn)
        (s_addr_done ##0 (asel_s && sh_q[7:1] == I2C_ADDR_HI))
        |=> (st_q == ST_ACK && i2c_oe_q) ##1 sensor_serial_in_io_oe)
        else $error("high address not acknowledged");

    a_addr_low: assert property (
        @(posedge mclk) disable iff (!rstn)
        (s_addr_done ##0 (!asel_s && sh_q[7:1] == I2C_ADDR_LO))
        |=> (st_q == ST_ACK && i2c_oe_q))
        else $error("low address not acknowledged");

    a_addr_miss: assert property (
        @(posedge mclk) disable iff (!rstn)
        (s_addr_done ##0 (sh_q[7:1] != own_addr))
        |=> (st_q == ST_IDLE && !i2c_oe_q))
        else $error("foreign address acknowledged");

    a_ack_on_data: assert property (
        @(posedge mclk) disable iff (!rstn)
        (st_q == ST_ACK) |-> ##1 (sensor_serial_in_io_oe || st_q != ST_ACK))
        else $error("ack not driven on data-in pin");

    a_sample_load: assert property (
        @(posedge mclk) disable iff (!rstn)
        (accel_valid && !freeze)
        |=> (data_q == $past(accel_sample) && ready_q)
            ##1 (sensor_irq_first == cfg_q[CFG_IRQ1_EN] || !ready_q))
        else $error("sample not loaded into data registers");

endmodule : ashl_top

// ===== verification/ashl_master.sv
// Purpose: master logic model at the far end of the sensor link
// Assumes: spi mode 3, 80 ns serial clock, still between frames
// Notes:   i2c data is open drain, a 1 here only releases the line
`timescale 1ns/1ns
module ashl_master (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    output logic      m_oe,
    input  wire logic sdi,
    input  wire logic sdo
);
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b1;
        m_oe = 1'b1;
    end
    task automatic sel(input logic lvl);
        cs_n = lvl;
        #80;
    endtask : sel
    task automatic spi_xfer(input logic [7:0] tx, input logic rd3,
                            output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sclk = 1'b0;
            m_oe = ~rd3;
            mosi = tx[i];
            #40 sclk = 1'b1;
            rx[i] = rd3 ? sdi : sdo;
            #40;
        end
    endtask : spi_xfer
    task automatic i2c_cond(input logic lvl);
        sclk = 1'b0;
        m_oe = 1'b1;
        #40 mosi = ~lvl;
        #40 sclk = 1'b1;
        #40 mosi = lvl;
        #80;
    endtask : i2c_cond
    task automatic i2c_byte(input logic [7:0] tx, output logic ack,
                            output logic [7:0] rx);
        for (int i = 7; i >= -1; i--)
        begin
            sclk = 1'b0;
            #40 mosi = (i < 0) | tx[i & 7];
            #40 sclk = 1'b1;
            ack = ~sdi;
            if (i >= 0)
                rx[i] = sdi;
            #80;
        end
    endtask : i2c_byte
endmodule : ashl_master

// ===== verification/accel_sensor_host_link_bench.sv
// Purpose: self-checking bench of the sensor side of the link
// Assumes: 125 MHz system clock, master model on the serial pins
// Notes:   pin levels resolved here from every party's enable
`timescale 1ns/1ns
module accel_sensor_host_link_bench;
    import ashl_pkg::*;
    logic              mclk, rstn, sclk, cs_n, mosi, m_oe, io, sel, ack;
    logic              io_o, io_oe, sel_o, sel_oe, irq1, irq2, valid, lvl;
    logic [1:0]        irq_s, irq2_s;
    logic [7:0]        rx;
    logic [1:0][7:0]   ab;
    ashl_sample_t      smp;
    int                seed, bad_count, checked;
    assign io  = io_oe ? io_o : (m_oe ? mosi : 1'b1);
    assign sel = sel_oe ? sel_o : lvl;
    always #4 mclk = ~mclk;
    always @(posedge mclk) irq_s <= {irq_s[0], irq1};
    always @(posedge mclk) irq2_s <= {irq2_s[0], irq2};
    ashl_top i_dut (.mclk(mclk), .rstn(rstn), .sensor_serial_clock(sclk),
        .sensor_mode_select_n(cs_n), .sensor_serial_in_io_i(io),
        .sensor_serial_in_io_o(io_o), .sensor_serial_in_io_oe(io_oe),
        .sensor_serial_out_addr_sel_i(sel),
        .sensor_serial_out_addr_sel_o(sel_o),
        .sensor_serial_out_addr_sel_oe(sel_oe), .sensor_irq_first(irq1),
        .sensor_irq_second(irq2), .accel_sample(smp), .accel_valid(valid));
    ashl_master i_mst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .m_oe(m_oe),
        .sdi(io), .sdo(sel));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic load();
        @(posedge mclk) #1;
        smp = 48'({$random(seed), $random(seed)});
        valid = 1'b1;
        @(posedge mclk) #1 valid = 1'b0;
        repeat (6) @(posedge mclk);
        // serial pins then move off the mclk edge
        #1;
    endtask : load
    task automatic spi_rd(input logic three);
        i_mst.sel(1'b0);
        i_mst.spi_xfer(8'h80, 1'b0, rx);
        for (int k = 0; k < 6; k++)
        begin
            i_mst.spi_xfer(8'($random(seed)), three, rx);
            chk(rx, smp[8*k +: 8]);
        end
        i_mst.sel(1'b1);
    endtask : spi_rd
    task automatic summarize();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial
    begin
        #200000;
        bad_count++;
        summarize();
    end
    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        valid = 1'b0;
        lvl = 1'b1;
        smp = '0;
        irq_s = 2'b00;
        irq2_s = 2'b00;
        ab = {8'h3A, 8'hA6};
        seed = 36517;
        bad_count = 0;
        checked = 0;
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge mclk);
        load();
        spi_rd(1'b0);
        i_mst.sel(1'b0);
        i_mst.spi_xfer(8'h07, 1'b0, rx);
        i_mst.spi_xfer(8'h03, 1'b0, rx);
        // wraps to a read-only byte, which must be ignored
        i_mst.spi_xfer(8'h5A, 1'b0, rx);
        i_mst.sel(1'b1);
        load();
        chk({7'h00, irq_s[1]}, 8'h01);
        spi_rd(1'b1);
        chk({7'h00, sel_oe}, 8'h00);
        // each level against both address bytes, one match each
        for (int j = 0; j < 4; j++)
        begin
            lvl = j[1];
            i_mst.i2c_cond(1'b0);
            i_mst.i2c_byte(ab[j[0]], ack, rx);
            i_mst.i2c_cond(1'b1);
            chk({7'h00, ack}, {7'h00, j[0] == j[1]});
        end
        // config over i2c, then a double load must flag overrun
        i_mst.i2c_cond(1'b0);
        i_mst.i2c_byte(8'h3A, ack, rx);
        chk({7'h00, ack}, 8'h01);
        i_mst.i2c_byte({5'h00, REG_CONFIG}, ack, rx);
        chk({7'h00, ack}, 8'h01);
        i_mst.i2c_byte(8'((1 << CFG_IRQ1_EN) | (1 << CFG_IRQ2_EN)), ack, rx);
        chk({7'h00, ack}, 8'h01);
        i_mst.i2c_cond(1'b1);
        load();
        load();
        chk({6'h00, irq2_s[1], irq_s[1]}, 8'h03);
        // pointer wrapped past config, so the read starts at x low
        i_mst.i2c_cond(1'b0);
        i_mst.i2c_byte(8'h3B, ack, rx);
        chk({7'h00, ack}, 8'h01);
        i_mst.i2c_byte(8'hFF, ack, rx);
        chk(rx, smp[7:0]);
        i_mst.i2c_cond(1'b1);
        summarize();
    end
endmodule : accel_sensor_host_link_bench
